// File: hdl/shutdown_seq_map.vh
// offsets, fields, reset values and timing counts of the shutdown write sequencer
`ifndef SHUTDOWN_SEQ_MAP_VH
`define SHUTDOWN_SEQ_MAP_VH

// ---------------------------------------------------------------
// apb register byte addresses
// ---------------------------------------------------------------
`define SEQ_ADDR_CTRL        12'h1BC
`define SEQ_ADDR_STATUS      12'h1C0
`define SEQ_ADDR_WIN_BASE    12'h000
`define SEQ_WIN_WORDS        256
`define SEQ_ADDR_WIN_LAST    12'h3FC

// ---------------------------------------------------------------
// control word and fields
// ---------------------------------------------------------------
`define SEQ_CTRL_SHUTDOWN    16'h0119
`define SEQ_CTRL_START_BIT   8
`define SEQ_CTRL_INDEX_LSB   0
`define SEQ_CTRL_INDEX_MSB   5
`define SEQ_STATUS_BUSY_BIT  0

// ---------------------------------------------------------------
// sequence indices
// ---------------------------------------------------------------
`define SEQ_FIRST_INDEX      6'h19
`define SEQ_LAST_INDEX       6'h27

// ---------------------------------------------------------------
// target register offsets and reset values
// ---------------------------------------------------------------
`define TGT_BIAS             8'h04
`define TGT_MIDRAIL          8'h05
`define TGT_PHONES_GAIN      8'h0E
`define TGT_LINE_GAIN        8'h0F
`define TGT_CONVERTER        8'h12
`define TGT_CLOCKS           8'h16
`define TGT_SERVO            8'h43
`define TGT_PHONES_OUT       8'h5A
`define TGT_LINE_OUT         8'h5E
`define TGT_CHARGE_PUMP      8'h62
`define TGT_RESET_VALUE      16'h0000

// ---------------------------------------------------------------
// timing: base delay step 0.5625 ms at 125 MHz
// ---------------------------------------------------------------
`define CLK_FREQ_HZ          125000000
`define DELAY_BASE_NS        562500
`define DELAY_BASE_CYCLES    70313
`define DELAY_HALF_NS        62500
`define DELAY_HALF_CYCLES    7813

`endif

// File: hdl/seq_step_rom.v
// fixed entries of the default shutdown program, indices 19h to 27h
`timescale 1ns/100ps
`include "shutdown_seq_map.vh"
module seq_step_rom (
    // entry select
    input  wire [5:0] index,
    // entry contents
    output reg  [7:0] tgt_addr,
    output reg  [2:0] width_m1,
    output reg  [3:0] start_bit,
    output reg  [7:0] data,
    output reg  [3:0] delay_code,
    output reg        end_flag
);

    // ---------------------------------------------------------------
    // entry table
    // ---------------------------------------------------------------
    // lookup of the stored program
    always @* begin
        tgt_addr   = 8'h00;
        width_m1   = 3'h0;
        start_bit  = 4'h0;
        data       = 8'h00;
        delay_code = 4'h0;
        end_flag   = 1'b0;
        case (index)
            6'h19: begin
                tgt_addr = `TGT_LINE_OUT; width_m1 = 3'h7; data = 8'h77;
            end
            6'h1A: begin
                tgt_addr = `TGT_PHONES_OUT; width_m1 = 3'h7; data = 8'h77;
            end
            6'h1B: begin
                tgt_addr = `TGT_PHONES_OUT; width_m1 = 3'h7;
            end
            6'h1C: begin
                tgt_addr = `TGT_LINE_OUT; width_m1 = 3'h7;
            end
            6'h1D: begin
                tgt_addr = `TGT_SERVO; width_m1 = 3'h3;
            end
            6'h1E: begin
                tgt_addr = `TGT_CHARGE_PUMP;
            end
            6'h1F: begin
                tgt_addr = `TGT_CONVERTER; width_m1 = 3'h1; start_bit = 4'h2;
            end
            6'h20: begin
                tgt_addr = `TGT_CLOCKS; start_bit = 4'h1;
            end
            6'h21: begin
                tgt_addr = `TGT_PHONES_GAIN; width_m1 = 3'h1;
            end
            6'h22: begin
                tgt_addr = `TGT_LINE_GAIN; width_m1 = 3'h1;
            end
            6'h23: begin
                tgt_addr = `TGT_BIAS;
            end
            6'h24: begin
                tgt_addr = `TGT_MIDRAIL; delay_code = 4'hC;
            end
            6'h25: begin
                tgt_addr = `TGT_MIDRAIL; delay_code = 4'h9;
            end
            6'h26: begin
                tgt_addr = `TGT_MIDRAIL; width_m1 = 3'h7;
            end
            6'h27: begin
                tgt_addr = `TGT_BIAS; width_m1 = 3'h1; end_flag = 1'b1;
            end
            default: begin
                end_flag = 1'b1;
            end
        endcase
    end

endmodule // seq_step_rom

// File: hdl/shutdown_sequencer.v
// apb control write sequencer running the default shutdown program
//
// Summary of operation
// - writing 0119h to control starts shutdown
// - begin at index 19h, step consecutively
// - whole program about 296 ms
// - entry 25 clears line short removal
// - entry 26 clears phones short removal
// - entry 27 clears phones output enables
// - entry 28 clears line output enables
// - entry 29 turns offset servos off
// - entry 30 turns charge pump off
// - entry 31 turns both converters off
// - entry 32 stops processor clock
// - entry 33 turns phones gain off
// - entry 34 turns line gain off
// - entry 35 turns bias off
// - entry 36 midrail off, 256.5 ms
// - entry 37 midrail off, 32.5 ms
// - entry 38 clears midrail register byte
// - entry 39 ends the sequence
// - busy flag high while running
`timescale 1ns/100ps
`include "shutdown_seq_map.vh"
module shutdown_sequencer #(
    parameter BASE_CYCLES = `DELAY_BASE_CYCLES,
    parameter HALF_CYCLES = `DELAY_HALF_CYCLES
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // status
    output reg         busy
);

    // ---------------------------------------------------------------
    // state and storage
    // ---------------------------------------------------------------
    localparam ST_IDLE  = 2'd0;
    localparam ST_WRITE = 2'd1;
    localparam ST_WAIT  = 2'd2;

    reg [1:0]  state_r;
    reg [5:0]  index_r;
    reg [31:0] wait_r;
    reg        last_r;
    reg [15:0] ctrl_r;
    reg [15:0] tgt_r [0:`SEQ_WIN_WORDS-1];

    wire [7:0] e_addr;
    wire [2:0] e_wm1;
    wire [3:0] e_start;
    wire [7:0] e_data;
    wire [3:0] e_delay;
    wire       e_end;

    seq_step_rom u_rom (
        .index      (index_r),
        .tgt_addr   (e_addr),
        .width_m1   (e_wm1),
        .start_bit  (e_start),
        .data       (e_data),
        .delay_code (e_delay),
        .end_flag   (e_end)
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // delay in cycles: base minus one half step plus 2^code half steps
    function [31:0] delay_cycles;
        input [3:0] code;
        begin
            // code 0 gives base; ch gives 256.5 ms, 9h gives 32.5 ms
            if (code == 4'h0)
                delay_cycles = BASE_CYCLES;
            else
                delay_cycles = ((32'd1 << code) * HALF_CYCLES) + BASE_CYCLES - HALF_CYCLES;
        end
    endfunction

    // field mask of width and start
    function [15:0] field_mask;
        input [2:0] wm1;
        input [3:0] sb;
        reg   [15:0] m;
        begin
            m = (16'h0002 << wm1) - 16'h0001;
            field_mask = m << sb;
        end
    endfunction

    wire        acc      = psel & penable & ~pready;
    wire        wr_acc   = acc & pwrite;
    wire        in_win   = (paddr <= `SEQ_ADDR_WIN_LAST);
    wire [7:0]  win_idx  = paddr[9:2];
    wire        is_ctrl  = (paddr == `SEQ_ADDR_CTRL);
    wire        is_stat  = (paddr == `SEQ_ADDR_STATUS);
    wire        ok_addr  = (paddr[1:0] == 2'b00) & (in_win | is_stat);
    wire [15:0] wdat16   = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};
    wire [15:0] fmask    = field_mask(e_wm1, e_start);
    wire [15:0] fval     = ({8'h00, e_data} << e_start) & fmask;
    wire        launch   = wr_acc & is_ctrl & (pwdata[15:0] == `SEQ_CTRL_SHUTDOWN) & pstrb[1] & pstrb[0];

    // ---------------------------------------------------------------
    // apb response
    // ---------------------------------------------------------------
    // single wait state: answer on second access edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= acc;
            pslverr <= acc & ~ok_addr;
            prdata  <= 32'h0000_0000;
            if (acc & ~pwrite & ok_addr) begin
                if (is_stat)
                    prdata <= {31'h0000_0000, busy};
                else if (is_ctrl)
                    prdata <= {16'h0000, ctrl_r};
                else
                    prdata <= {16'h0000, tgt_r[win_idx]};
            end
        end
    end

    // ---------------------------------------------------------------
    // sequencer engine
    // ---------------------------------------------------------------
    // fetch, masked write, delay, advance
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            index_r <= 6'h00;
            wait_r  <= 32'h0000_0000;
            last_r  <= 1'b0;
            busy    <= 1'b0;
            ctrl_r  <= 16'h0000;
        end else begin
            if (wr_acc & is_ctrl & pstrb[0])
                ctrl_r <= wdat16;
            case (state_r)
                ST_IDLE: begin
                    if (launch) begin
                        index_r <= `SEQ_FIRST_INDEX;
                        busy    <= 1'b1;
                        state_r <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    wait_r  <= delay_cycles(e_delay) - 32'd1;
                    last_r  <= e_end;
                    state_r <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (wait_r != 32'h0000_0000) begin
                        wait_r <= wait_r - 32'd1;
                    end else if (last_r) begin
                        busy    <= 1'b0;
                        state_r <= ST_IDLE;
                    end else begin
                        index_r <= index_r + 6'h01;
                        state_r <= ST_WRITE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    busy    <= 1'b0;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // target register window
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `SEQ_WIN_WORDS; g = g + 1) begin : g_tgt
            // host write or sequencer masked write
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tgt_r[g] <= `TGT_RESET_VALUE;
                end else if ((state_r == ST_WRITE) && (e_addr == g)) begin
                    tgt_r[g] <= (tgt_r[g] & ~fmask) | fval;
                end else if (wr_acc && in_win && (paddr[1:0] == 2'b00) && (win_idx == g) && !is_ctrl) begin
                    tgt_r[g] <= (tgt_r[g] & ~{{8{pstrb[1]}}, {8{pstrb[0]}}}) | wdat16;
                end
            end
        end
    endgenerate

endmodule // shutdown_sequencer

// File: dv/seq_checker.sv
// bus and run-length assertions of the shutdown sequencer
`timescale 1ns/100ps
`include "shutdown_seq_map.vh"
module seq_checker #(
    parameter BASE_CYCLES = `DELAY_BASE_CYCLES,
    parameter HALF_CYCLES = `DELAY_HALF_CYCLES
) (
    // clock, reset and bus
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        busy
);
    localparam integer TOTAL = 15 + 15 * BASE_CYCLES + 4606 * HALF_CYCLES;
    wire       acc = psel && penable && !pready;
    wire       bad = (paddr[1:0] != 2'h0) || (paddr >= 12'h400);
    reg [31:0] run_r;
    // cycles spent running
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            run_r <= 32'h0000_0000;
        else if (!busy)
            run_r <= 32'h0000_0000;
        else
            run_r <= run_r + 32'h0000_0001;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_after_access_a:
        assert property (acc |=> pready) else $error("no pready after access");
    ready_one_cycle_a:
        assert property (pready |=> !pready) else $error("pready held too long");
    error_on_bad_a:
        assert property (acc && bad |=> pslverr) else $error("bad address accepted");
    no_error_good_a:
        assert property (acc && !bad |=> !pslverr) else $error("good address refused");
    launch_sets_busy_a:
        assert property (acc && pwrite && paddr == `SEQ_ADDR_CTRL && pwdata[15:0] == `SEQ_CTRL_SHUTDOWN
            |=> ##[0:1] busy) else $error("launch did not start");
    busy_holds_a:
        assert property ($rose(busy) |-> busy [*8]) else $error("run ended too soon");
    run_bound_a:
        assert property (run_r <= TOTAL + 4) else $error("run too long");
    run_length_a:
        assert property ($fell(busy) |-> run_r + 4 >= TOTAL) else $error("run too short");
    upper_zero_a:
        assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000) else $error("upper half not zero");
    status_busy_a:
        assert property (pready && !pwrite && paddr == `SEQ_ADDR_STATUS |-> prdata[0] == $past(busy))
            else $error("status busy mismatch");
endmodule // seq_checker

// File: dv/shutdown_sequencer_bench.sv
// self-checking bench of the shutdown sequencer
`timescale 1ns/100ps
`include "shutdown_seq_map.vh"
module shutdown_sequencer_bench;
    localparam integer BASE = 9;
    localparam integer HALF = 1;
    localparam [79:0] TGTS = 80'h0405_0E0F_1216_435A_5E62;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0000_0000;
    reg  [3:0]  pstrb = 4'hF;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        busy;
    integer     error_cnt = 0;
    integer     compares = 0;
    integer     seed = 72;
    integer     runs = 0;
    integer     i, tot;
    reg  [31:0] rd;
    reg         er;
    reg  [15:0] init_v [0:9];
    shutdown_sequencer #(.BASE_CYCLES(BASE), .HALF_CYCLES(HALF)) i_shutdown_sequencer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busy(busy));
    // clock and busy cycle count
    initial forever #4 pclk = ~pclk;
    always @(posedge pclk) if (busy === 1'b1) runs <= runs + 1;
    function [23:0] ent(input integer k);
        case (k)
            0: ent = 24'h5E_8077;
            1: ent = 24'h5A_8077;
            2: ent = 24'h5A_8000;
            3: ent = 24'h5E_8000;
            4: ent = 24'h43_4000;
            5: ent = 24'h62_1000;
            6: ent = 24'h12_2200;
            7: ent = 24'h16_1100;
            8: ent = 24'h0E_2000;
            9: ent = 24'h0F_2000;
            10: ent = 24'h04_1000;
            11: ent = 24'h05_1000;
            12: ent = 24'h05_1000;
            13: ent = 24'h05_8000;
            default: ent = 24'h04_2000;
        endcase
    endfunction
    function [7:0] tgt(input integer j);
        tgt = TGTS[79 - 8 * j -: 8];
    endfunction
    // masked field update after the first st entries
    function [15:0] expv(input [7:0] a, input [15:0] v, input integer st);
        integer    k;
        reg [23:0] e;
        reg [15:0] m;
        begin
            expv = v;
            for (k = 0; k < st; k = k + 1) begin
                e = ent(k);
                m = ((16'h0001 << e[15:12]) - 16'h0001) << e[11:8];
                if (e[23:16] == a) expv = (expv & ~m) | ((e[7:0] << e[11:8]) & m);
            end
        end
    endfunction
    function integer dly(input integer k);
        dly = (k == 11) ? BASE - HALF + 4096 * HALF : (k == 12) ? BASE - HALF + 512 * HALF : BASE;
    endfunction
    task apb(input w, input [11:0] a, input [31:0] d);
        integer t;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            t = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && t < 50) begin
                @(posedge pclk);
                t = t + 1;
            end
            if (t >= 50)
                error_cnt = error_cnt + 1;
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task chk(input [8*8-1:0] nm, input [31:0] exp, input [31:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("wrong value %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task chk_all(input integer st);
        for (i = 0; i < 10; i = i + 1) begin
            apb(1'b0, {2'h0, tgt(i), 2'h0}, 32'h0000_0000);
            chk("target", {16'h0000, expv(tgt(i), init_v[i], st)}, rd);
        end
    endtask
    task results;
        begin
            $display("errors %0d compares %0d", error_cnt, compares);
            if (error_cnt == 0 && compares > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // watchdog
    initial begin
        #(8 * 20000);
        error_cnt = error_cnt + 1;
        results;
    end
    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SEQ_ADDR_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0000, rd);
        apb(1'b1, 12'h16A, 32'h0000_FFFF);
        chk("slverr", 32'h1, {31'h0, er});
        apb(1'b0, 12'h400, 32'h0000_0000);
        chk("slverr", 32'h1, {31'h0, er});
        apb(1'b1, `SEQ_ADDR_CTRL, 32'h0000_0100);
        apb(1'b0, `SEQ_ADDR_CTRL, 32'h0000_0000);
        chk("control", 32'h0000_0100, rd);
        chk("busy", 32'h0, {31'h0, busy});
        for (i = 0; i < 10; i = i + 1) begin
            init_v[i] = $random(seed);
            apb(1'b1, {2'h0, tgt(i), 2'h0}, {16'h0000, init_v[i]});
        end
        chk_all(0);
        apb(1'b1, `SEQ_ADDR_CTRL, {16'h0000, `SEQ_CTRL_SHUTDOWN});
        apb(1'b0, `SEQ_ADDR_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0001, rd);
        apb(1'b1, `SEQ_ADDR_CTRL, {16'h0000, `SEQ_CTRL_SHUTDOWN});
        repeat (150) @(posedge pclk);
        chk_all(12);
        i = 0;
        while (busy !== 1'b0 && i < 9000) begin
            @(posedge pclk);
            i = i + 1;
        end
        chk("busy", 32'h0, {31'h0, busy});
        chk_all(15);
        tot = 0;
        for (i = 0; i < 15; i = i + 1) tot = tot + 1 + dly(i);
        chk("runtime", 32'h1, {31'h0, (runs + 4 >= tot) && (runs <= tot + 4)});
        results;
    end
endmodule // shutdown_sequencer_bench
bind shutdown_sequencer seq_checker #(.BASE_CYCLES(BASE_CYCLES), .HALF_CYCLES(HALF_CYCLES)) i_seq_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
